// File: paod_decoder.sv
// How it works
// - top bit zero means non-multiply parallel op
// - destination bit: 0 selects A, 1 B
// - source fields 1xx pick single register sources
// - all-zero byte is pure move, no ALU
// - byte 08 hex is reserved
// - 010/011 with qualifier low select pairs
// - full source group: add transfer sub compare
// - logical ops: or, exclusive-or, and
// - add-with-carry and subtract-with-borrow via pairs
// - 010 group: shifts right, absolute, rotate
// - 011 group: shifts left, negate, rotate
// - 001 group: round, add_shift_left_op, clear, subl, not
// - 000 group: addr, test, subtract_shift_right_op
// - bits 23..8 are the move field
// - word 000005 hex is the opcode_word_a opcode
`timescale 1ns/1ps
module paod_decoder (
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    input  wire logic                word_valid_in,
    input  wire logic [23:0]         word_in,
    input  wire logic                ext_needed_in,
    output paod_pkg::paod_dec_t      dec_out,
    output paod_pkg::paod_issue_t    issue_out,
    output logic                     fetch_ext_out,
    output logic                     exception_out
);
    import paod_pkg::*;

    typedef enum logic [1:0] {
        PAOD_ST_OPCODE = 2'b00,
        PAOD_ST_EXT    = 2'b01
    } paod_state_t;

    paod_state_t state_q;
    paod_state_t state_d;
    paod_dec_t   dec_d;
    paod_dec_t   dec_q;
    paod_issue_t issue_q;
    logic        fetch_ext_q;
    logic        exception_q;
    logic        take;
    logic        fault;

    default clocking a_clk @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    paod_op_table u_table (
        .op_byte_in (word_in[OP_W-1:0]),
        .word_in    (word_in),
        .dec_out    (dec_d)
    );

    // in the extension state the incoming word is an address, not an op
    assign take  = word_valid_in && (state_q == PAOD_ST_OPCODE)
                   && !word_in[OP_TOP_BIT];
    assign fault = dec_d.reserved || dec_d.opcode_word_a_word;

    always_comb begin
        state_d = state_q;
        case (state_q)
            PAOD_ST_OPCODE: begin
                if (take && !fault && ext_needed_in) begin
                    state_d = PAOD_ST_EXT;
                end
            end
            PAOD_ST_EXT: begin
                if (word_valid_in) begin
                    state_d = PAOD_ST_OPCODE;
                end
            end
            default: state_d = PAOD_ST_OPCODE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= PAOD_ST_OPCODE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            dec_q <= '0;
        end else if (take) begin
            dec_q <= dec_d;
            if (fault) begin
                dec_q.acc_write <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            issue_q     <= '0;
            exception_q <= 1'b0;
            fetch_ext_q <= 1'b0;
        end else begin
            issue_q.valid      <= take && !fault;
            issue_q.move_field <= word_in[MOVE_HI:MOVE_LO];
            issue_q.ext_needed <= take && !fault && ext_needed_in;
            issue_q.exception  <= take && fault;
            exception_q        <= take && fault;
            fetch_ext_q        <= take && !fault && ext_needed_in;
        end
    end

    assign dec_out       = dec_q;
    assign issue_out     = issue_q;
    assign fetch_ext_out = fetch_ext_q;
    assign exception_out = exception_q;

    a_move_no_write: assert property (
        take && word_in[OP_W-1:0] == OPB_MOVE && !dec_d.opcode_word_a_word
        |=> dec_out.pure_move && !dec_out.acc_write)
        else $error("pure move decoded with accumulator write");

    a_reserved_traps: assert property (
        take && word_in[OP_W-1:0] == OPB_RESERVED
        |=> exception_out && !issue_out.valid)
        else $error("reserved byte did not trap");

    a_opcode_word_a_traps: assert property (
        take && word_in == OPCODE_WORD_A
        |=> exception_out && dec_out.opcode_word_a_word)
        else $error("opcode_word_a word did not trap");

    a_fault_no_write: assert property (
        exception_out |-> !dec_out.acc_write && !issue_out.valid)
        else $error("faulting op still writes");

    a_dest_bit: assert property (
        take |=> dec_out.dest_b == $past(word_in[DEST_BIT]))
        else $error("destination bit wrong");

    a_move_field: assert property (
        take && !fault
        |=> issue_out.move_field == $past(word_in[MOVE_HI:MOVE_LO]))
        else $error("move field wrong");

    sequence s_ext_req;
        take && !fault && ext_needed_in;
    endsequence
    a_ext_fetch: assert property (
        s_ext_req |=> fetch_ext_out ##0 (state_q == PAOD_ST_EXT))
        else $error("extension word not requested");

    a_y1_src: assert property (
        take && word_in[SRC_HI:SRC_LO] == SRC_111
        && word_in != OPCODE_WORD_A
        |=> dec_out.src == PAOD_SRC_Y1)
        else $error("source 111 not lower y input");

    a_pair_src: assert property (
        take && word_in[SRC_HI:SRC_HI-1] == 2'h1 && !word_in[QUAL_BIT]
        && word_in[DEST_BIT-1:0] != LO_000
        |=> dec_out.src == ($past(word_in[SRC_LO]) ? PAOD_SRC_Y_PAIR
                                                   : PAOD_SRC_X_PAIR))
        else $error("pair source wrong");

    a_acc_src: assert property (
        take && word_in[SRC_HI:SRC_HI-1] == 2'h1 && word_in[QUAL_BIT]
        |=> dec_out.src == PAOD_SRC_OTHER_ACC)
        else $error("shift group source wrong");

endmodule : paod_decoder

// File: paod_pkg.sv
package paod_pkg;

    localparam int OP_W       = 8;
    localparam int WORD_W     = 24;
    localparam int MOVE_HI    = 23;
    localparam int MOVE_LO    = 8;
    localparam int MOVE_W     = 16;
    localparam int OP_TOP_BIT = 7;
    localparam int SRC_HI     = 6;
    localparam int SRC_LO     = 4;
    localparam int DEST_BIT   = 3;
    localparam int QUAL_BIT   = 1;

    localparam logic [7:0]  OPB_MOVE     = 8'h00;
    localparam logic [7:0]  OPB_RESERVED = 8'h08;
    localparam logic [23:0] OPCODE_WORD_A = 24'h000005;

    localparam logic [2:0] SRC_000 = 3'h0;
    localparam logic [2:0] SRC_001 = 3'h1;
    localparam logic [2:0] SRC_010 = 3'h2;
    localparam logic [2:0] SRC_011 = 3'h3;
    localparam logic [2:0] SRC_111 = 3'h7;

    localparam logic [2:0] LO_000 = 3'h0;
    localparam logic [2:0] LO_001 = 3'h1;
    localparam logic [2:0] LO_010 = 3'h2;
    localparam logic [2:0] LO_011 = 3'h3;
    localparam logic [2:0] LO_100 = 3'h4;
    localparam logic [2:0] LO_101 = 3'h5;
    localparam logic [2:0] LO_110 = 3'h6;
    localparam logic [2:0] LO_111 = 3'h7;

    typedef enum logic [5:0] {
        PAOD_OP_NONE            = 6'h00,
        PAOD_OP_ADD             = 6'h01,
        PAOD_OP_TRANSFER        = 6'h02,
        PAOD_OP_OR              = 6'h03,
        PAOD_OP_EXCLUSIVE_OR    = 6'h04,
        PAOD_OP_SUB             = 6'h05,
        PAOD_OP_CMP             = 6'h06,
        PAOD_OP_AND             = 6'h07,
        PAOD_OP_CMP_MAGNITUDE   = 6'h08,
        PAOD_OP_ADD_CARRY       = 6'h09,
        PAOD_OP_SUB_BORROW      = 6'h0a,
        PAOD_OP_ARITH_SHIFT_R   = 6'h0b,
        PAOD_OP_LOGIC_SHIFT_R   = 6'h0c,
        PAOD_OP_ABSOLUTE_VALUE  = 6'h0d,
        PAOD_OP_ROTATE_R        = 6'h0e,
        PAOD_OP_ARITH_SHIFT_L   = 6'h0f,
        PAOD_OP_LOGIC_SHIFT_L   = 6'h10,
        PAOD_OP_NEGATE          = 6'h11,
        PAOD_OP_ROTATE_L        = 6'h12,
        PAOD_OP_ROUND           = 6'h13,
        PAOD_OP_ADD_SHIFT_L     = 6'h14,
        PAOD_OP_CLEAR           = 6'h15,
        PAOD_OP_SUB_SHIFT_L     = 6'h16,
        PAOD_OP_ONES_COMPLEMENT = 6'h17,
        PAOD_OP_ADD_SHIFT_R     = 6'h18,
        PAOD_OP_TEST_ACC        = 6'h19,
        PAOD_OP_SUB_SHIFT_R     = 6'h1a
    } paod_op_t;

    typedef enum logic [2:0] {
        PAOD_SRC_NONE      = 3'h0,
        PAOD_SRC_OTHER_ACC = 3'h1,
        PAOD_SRC_X_PAIR    = 3'h2,
        PAOD_SRC_Y_PAIR    = 3'h3,
        PAOD_SRC_X0        = 3'h4,
        PAOD_SRC_Y0        = 3'h5,
        PAOD_SRC_X1        = 3'h6,
        PAOD_SRC_Y1        = 3'h7
    } paod_src_t;

    typedef struct packed {
        paod_op_t    op;
        paod_src_t   src;
        logic        dest_b;
        logic        pure_move;
        logic        acc_write;
        logic        reserved;
        logic        opcode_word_a_word;
    } paod_dec_t;

    typedef struct packed {
        logic              valid;
        logic [MOVE_W-1:0] move_field;
        logic              ext_needed;
        logic              exception;
    } paod_issue_t;

endpackage : paod_pkg

// File: paod_op_table.sv
`timescale 1ns/1ps
module paod_op_table (
    input  wire logic [7:0]  op_byte_in,
    input  wire logic [23:0] word_in,
    output paod_pkg::paod_dec_t dec_out
);
    import paod_pkg::*;

    logic [2:0] src_sel;
    logic [2:0] low;
    logic       qual;

    assign src_sel = op_byte_in[SRC_HI:SRC_LO];
    assign low     = op_byte_in[2:0];
    assign qual    = op_byte_in[QUAL_BIT];

    always_comb begin
        dec_out              = '0;
        dec_out.op           = PAOD_OP_NONE;
        dec_out.src          = PAOD_SRC_NONE;
        dec_out.dest_b       = op_byte_in[DEST_BIT];
        dec_out.opcode_word_a_word = (word_in == OPCODE_WORD_A);
        if (op_byte_in[OP_TOP_BIT]) begin
            // multiply group is decoded elsewhere
            dec_out.reserved = 1'b0;
        end else if (op_byte_in == OPB_MOVE) begin
            dec_out.pure_move = 1'b1;
        end else if (op_byte_in == OPB_RESERVED) begin
            dec_out.reserved = 1'b1;
        end else begin
            dec_out.reserved = 1'b1;
            case (src_sel)
                SRC_000: begin
                    dec_out.src      = PAOD_SRC_OTHER_ACC;
                    dec_out.reserved = 1'b0;
                    case (low)
                        LO_001:  dec_out.op = PAOD_OP_TRANSFER;
                        LO_010:  dec_out.op = PAOD_OP_ADD_SHIFT_R;
                        LO_011:  dec_out.op = PAOD_OP_TEST_ACC;
                        LO_101:  dec_out.op = PAOD_OP_CMP;
                        LO_110:  dec_out.op = PAOD_OP_SUB_SHIFT_R;
                        LO_111:  dec_out.op = PAOD_OP_CMP_MAGNITUDE;
                        default: dec_out.reserved = 1'b1;
                    endcase
                end
                SRC_001: begin
                    dec_out.src      = PAOD_SRC_OTHER_ACC;
                    dec_out.reserved = 1'b0;
                    case (low)
                        LO_000:  dec_out.op = PAOD_OP_ADD;
                        LO_001:  dec_out.op = PAOD_OP_ROUND;
                        LO_010:  dec_out.op = PAOD_OP_ADD_SHIFT_L;
                        LO_011:  dec_out.op = PAOD_OP_CLEAR;
                        LO_100:  dec_out.op = PAOD_OP_SUB;
                        LO_110:  dec_out.op = PAOD_OP_SUB_SHIFT_L;
                        LO_111:  dec_out.op = PAOD_OP_ONES_COMPLEMENT;
                        default: dec_out.reserved = 1'b1;
                    endcase
                end
                SRC_010, SRC_011: begin
                    dec_out.reserved = 1'b0;
                    if (qual) begin
                        dec_out.src = PAOD_SRC_OTHER_ACC;
                        case ({src_sel[0], low})
                            {1'b0, LO_010}: dec_out.op = PAOD_OP_ARITH_SHIFT_R;
                            {1'b0, LO_011}: dec_out.op = PAOD_OP_LOGIC_SHIFT_R;
                            {1'b0, LO_110}: dec_out.op = PAOD_OP_ABSOLUTE_VALUE;
                            {1'b0, LO_111}: dec_out.op = PAOD_OP_ROTATE_R;
                            {1'b1, LO_010}: dec_out.op = PAOD_OP_ARITH_SHIFT_L;
                            {1'b1, LO_011}: dec_out.op = PAOD_OP_LOGIC_SHIFT_L;
                            {1'b1, LO_110}: dec_out.op = PAOD_OP_NEGATE;
                            {1'b1, LO_111}: dec_out.op = PAOD_OP_ROTATE_L;
                            default:        dec_out.reserved = 1'b1;
                        endcase
                    end else begin
                        dec_out.src = src_sel[0] ? PAOD_SRC_Y_PAIR
                                                 : PAOD_SRC_X_PAIR;
                        case (low)
                            LO_000:  dec_out.op = PAOD_OP_ADD;
                            LO_001:  dec_out.op = PAOD_OP_ADD_CARRY;
                            LO_100:  dec_out.op = PAOD_OP_SUB;
                            LO_101:  dec_out.op = PAOD_OP_SUB_BORROW;
                            default: dec_out.reserved = 1'b1;
                        endcase
                    end
                end
                default: begin
                    dec_out.reserved = 1'b0;
                    case (src_sel)
                        3'h4:    dec_out.src = PAOD_SRC_X0;
                        3'h5:    dec_out.src = PAOD_SRC_Y0;
                        3'h6:    dec_out.src = PAOD_SRC_X1;
                        default: dec_out.src = PAOD_SRC_Y1;
                    endcase
                    case (low)
                        LO_000:  dec_out.op = PAOD_OP_ADD;
                        LO_001:  dec_out.op = PAOD_OP_TRANSFER;
                        LO_010:  dec_out.op = PAOD_OP_OR;
                        LO_011:  dec_out.op = PAOD_OP_EXCLUSIVE_OR;
                        LO_100:  dec_out.op = PAOD_OP_SUB;
                        LO_101:  dec_out.op = PAOD_OP_CMP;
                        LO_110:  dec_out.op = PAOD_OP_AND;
                        default: dec_out.op = PAOD_OP_CMP_MAGNITUDE;
                    endcase
                end
            endcase
        end
        // the opcode_word_a word has low byte 05, so it would
        // otherwise decode as a compare with the other accumulator
        if (dec_out.opcode_word_a_word) begin
            dec_out.op       = PAOD_OP_NONE;
            dec_out.src      = PAOD_SRC_NONE;
            dec_out.reserved = 1'b0;
        end
        dec_out.acc_write = (dec_out.op != PAOD_OP_NONE)
                            && (dec_out.op != PAOD_OP_TEST_ACC)
                            && (dec_out.op != PAOD_OP_CMP)
                            && (dec_out.op != PAOD_OP_CMP_MAGNITUDE);
    end

endmodule : paod_op_table

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import paod_pkg::*;

    logic        clk_in;
    logic        reset_in;
    logic        word_valid_in;
    logic        ext_needed_in;
    logic [23:0] word_in;
    paod_dec_t   dec_out;
    paod_issue_t issue_out;
    logic        fetch_ext_out;
    logic        exception_out;
    int          fails;
    int          check_count;
    paod_dec_t   held;

    localparam paod_op_t T0 [8] = '{PAOD_OP_NONE, PAOD_OP_TRANSFER,
        PAOD_OP_ADD_SHIFT_R, PAOD_OP_TEST_ACC, PAOD_OP_NONE, PAOD_OP_CMP,
        PAOD_OP_SUB_SHIFT_R, PAOD_OP_CMP_MAGNITUDE};
    localparam paod_op_t T1 [8] = '{PAOD_OP_ADD, PAOD_OP_ROUND,
        PAOD_OP_ADD_SHIFT_L, PAOD_OP_CLEAR, PAOD_OP_SUB, PAOD_OP_NONE,
        PAOD_OP_SUB_SHIFT_L, PAOD_OP_ONES_COMPLEMENT};
    localparam paod_op_t T2 [8] = '{PAOD_OP_ADD, PAOD_OP_ADD_CARRY,
        PAOD_OP_ARITH_SHIFT_R, PAOD_OP_LOGIC_SHIFT_R, PAOD_OP_SUB,
        PAOD_OP_SUB_BORROW, PAOD_OP_ABSOLUTE_VALUE, PAOD_OP_ROTATE_R};
    localparam paod_op_t T3 [8] = '{PAOD_OP_ADD, PAOD_OP_ADD_CARRY,
        PAOD_OP_ARITH_SHIFT_L, PAOD_OP_LOGIC_SHIFT_L, PAOD_OP_SUB,
        PAOD_OP_SUB_BORROW, PAOD_OP_NEGATE, PAOD_OP_ROTATE_L};
    localparam paod_op_t TF [8] = '{PAOD_OP_ADD, PAOD_OP_TRANSFER,
        PAOD_OP_OR, PAOD_OP_EXCLUSIVE_OR, PAOD_OP_SUB, PAOD_OP_CMP,
        PAOD_OP_AND, PAOD_OP_CMP_MAGNITUDE};

    paod_decoder paod_decoder_inst (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .word_valid_in (word_valid_in),
        .word_in       (word_in),
        .ext_needed_in (ext_needed_in),
        .dec_out       (dec_out),
        .issue_out     (issue_out),
        .fetch_ext_out (fetch_ext_out),
        .exception_out (exception_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_vec

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : cmp_bit

    // expected decode of one op byte; sc is low where no operand exists
    function automatic void model(input logic [7:0] b, output paod_dec_t e,
                                  output bit sc);
        logic [2:0] j;
        logic [2:0] k;
        j = b[6:4];
        k = b[2:0];
        e = '0;
        e.dest_b = b[3];
        e.src = PAOD_SRC_OTHER_ACC;
        case (j)
            3'h0: e.op = T0[k];
            3'h1: e.op = T1[k];
            3'h2, 3'h3: begin
                if (!k[1])
                    e.src = j[0] ? PAOD_SRC_Y_PAIR : PAOD_SRC_X_PAIR;
                e.op = j[0] ? T3[k] : T2[k];
            end
            // enum order of the single registers follows the field value
            default: begin
                e.op = TF[k];
                e.src = paod_src_t'(j);
            end
        endcase
        e.reserved = (b == OPB_RESERVED) || (j == 3'h0 && k == 3'h4)
                     || (j == 3'h1 && k == 3'h5);
        e.pure_move = (b == OPB_MOVE);
        if (e.reserved)
            e.op = PAOD_OP_NONE;
        sc = !(j == 3'h0 && k == 3'h3) && !(j == 3'h1 && k[0]) && !e.pure_move;
        e.acc_write = !e.reserved && !e.pure_move && !(e.op inside
            {PAOD_OP_TEST_ACC, PAOD_OP_CMP, PAOD_OP_CMP_MAGNITUDE});
    endfunction : model

    task automatic apply(input logic [23:0] w, input logic v, input logic x);
        word_in = w;
        word_valid_in = v;
        ext_needed_in = x;
        @(posedge clk_in);
        #1;
    endtask : apply

    task automatic do_word(input logic [23:0] w, input logic x);
        paod_dec_t e;
        bit        sc;
        logic      xx;
        logic [23:0] ew;
        e = '0;
        sc = 1'b0;
        if (!w[7])
            model(w[7:0], e, sc);
        // no extension asked on refused words: their follow-up is unspecified
        xx = x && !w[7] && !e.reserved && (w != OPCODE_WORD_A);
        held = dec_out;
        apply(w, 1'b1, xx);
        cmp_vec(32'(issue_out.move_field), 32'(w[23:8]), "move field");
        if (w[7]) begin
            cmp_vec(32'(dec_out), 32'(held), "multiply decoded");
            cmp_bit(issue_out.valid, 1'b0, "multiply valid");
            cmp_bit(exception_out, 1'b0, "multiply exc");
            return;
        end
        if (w == OPCODE_WORD_A) begin
            cmp_bit(dec_out.opcode_word_a_word, 1'b1, "opcode_word_a flag");
            cmp_bit(exception_out, 1'b1, "opcode_word_a exception");
            cmp_bit(issue_out.exception, 1'b1, "opcode_word_a issue");
            cmp_bit(issue_out.valid, 1'b0, "opcode_word_a valid");
            cmp_bit(dec_out.acc_write, 1'b0, "opcode_word_a write");
            return;
        end
        cmp_bit(exception_out, e.reserved, "exception");
        cmp_bit(issue_out.valid, !e.reserved, "issue valid");
        cmp_bit(dec_out.acc_write, e.acc_write, "acc write");
        cmp_bit(issue_out.exception, e.reserved, "issue exc");
        cmp_bit(dec_out.reserved, e.reserved, "reserved");
        cmp_bit(dec_out.opcode_word_a_word, 1'b0, "opcode_word_a clear");
        cmp_bit(fetch_ext_out, xx, "fetch ext");
        cmp_bit(issue_out.ext_needed, xx, "issue ext");
        if (e.reserved) begin
            cmp_bit(dec_out.reserved, 1'b1, "reserved flag");
            return;
        end
        cmp_vec(32'(dec_out.op), 32'(e.op), "op");
        if (sc)
            cmp_vec(32'(dec_out.src), 32'(e.src), "source");
        cmp_bit(dec_out.dest_b, e.dest_b, "dest");
        cmp_bit(dec_out.pure_move, e.pure_move, "pure move");
        if (xx) begin
            held = dec_out;
            ew = 24'($urandom);
            apply(ew, 1'b1, 1'b0);
            cmp_vec(32'(dec_out), 32'(held), "ext word decoded");
            cmp_bit(issue_out.valid, 1'b0, "ext word valid");
        end
    endtask : do_word

    initial begin
        repeat (20000) @(posedge clk_in);
        fails++;
        finish_test();
    end

    initial begin
        logic [23:0] w;
        reset_in = 1'b1;
        word_valid_in = 1'b0;
        ext_needed_in = 1'b0;
        word_in = '0;
        fails = 0;
        check_count = 0;
        void'($urandom(32'heca7));
        repeat (12) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        apply(24'($urandom), 1'b0, 1'b0);
        cmp_vec(32'(dec_out), 32'h0, "decode after reset");
        for (int b = 0; b < 128; b++)
            do_word({16'($urandom), 8'(b)}, 1'(b[0] ^ b[3]));
        do_word(OPCODE_WORD_A, 1'b1);
        do_word(24'h0000d5, 1'b0);
        do_word(24'h00ff08, 1'b0);
        // reset in mid-run clears the held decode
        reset_in = 1'b1;
        apply(24'h000010, 1'b1, 1'b0);
        reset_in = 1'b0;
        cmp_vec(32'(dec_out), 32'h0, "decode in reset");
        apply(24'($urandom), 1'b0, 1'b0);
        for (int i = 0; i < 300; i++) begin
            w = 24'($urandom);
            do_word(w, ($urandom % 4) == 0);
            if (($urandom % 5) == 0) begin
                apply(24'($urandom), 1'b0, 1'b0);
                cmp_bit(issue_out.valid, 1'b0, "valid end");
                cmp_bit(exception_out, 1'b0, "exc end");
            end
        end
        finish_test();
    end
endmodule : tb_top
